// ---- rsw_consts.svh ----
// rsw_consts.svh - offsets, field positions, reset values and timing counts
// assumes inclusion by the top module and the bench of the reset source and watchdog block
`ifndef RSW_CONSTS_SVH
`define RSW_CONSTS_SVH
// register indices; byte address is four times the index
`define RSC_IDX 10'h0ef
`define WDC_IDX 10'h0ff
// reset_cause_and_force bit positions
`define RSC_PIN 0
`define RSC_POR 1
`define RSC_MCD 2
`define RSC_WDT 3
`define RSC_SW  4
`define RSC_CMP 5
`define RSC_CNV 6
// watchdog_control fields and command bytes
`define WDC_STATUS  4
`define WDC_CMD_BIT 7
`define WDC_RESTART 8'ha5
`define WDC_DIS1    8'hde
`define WDC_DIS2    8'had
`define WDC_LOCK    8'hff
`define WD_INTERVAL_RST 3'h7
`define WD_WINDOW       3'h4
`define WD_WIDTH        21
// timing
`define CLK_PERIOD_NS  10
`define MCD_TIMEOUT_NS 100000
`define PIN_STRETCH    4'hc
`define POR_DRIVE      5'h10
`endif

// ---- rsw_pkg.sv ----
// rsw_pkg.sv - types of the reset source and watchdog block
// assumes nothing beyond the constants header
package rsw_pkg;
  typedef enum logic [1:0] {RUN_ST, HOLD_ST, STRETCH_ST} seq_state_t;

  typedef struct packed {
    seq_state_t  seq;
    logic [3:0]  stretch;
    logic [4:0]  drive;
    logic [6:0]  cause;
    logic        cmp_en;
    logic        cnv_en;
    logic        wd_en;
    logic        wd_lock;
    logic [2:0]  interval;
    logic [2:0]  dis_win;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        pin_oe;
    logic        pin_out;
    logic        sys_rst;
    logic [1:0]  pin_sync;
    logic [1:0]  cmp_sync;
    logic [1:0]  cnv_sync;
    logic [1:0]  clk_sync;
  } top_state_t;
endpackage

// ---- missing_clock_monitor.sv ----
// missing_clock_monitor.sv - retriggered one-shot on the qualified system clock
// assumes clock_seen is already synchronised and enable is from the same domain
`timescale 1ns/1ps
module missing_clock_monitor #(
  parameter int CYCLES = 10000,
  parameter int W      = $clog2(CYCLES + 1)
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic clock_seen,
  output logic      timeout
);
  typedef struct packed {
    logic [W-1:0] idle;
    logic         timeout;
  } mcd_state_t;

  mcd_state_t s;
  mcd_state_t n;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  // every seen edge retriggers; idle count saturates so one pulse per outage
  always_comb begin
    n = s;
    n.timeout = 1'b0;
    if (!enable || clock_seen) begin
      n.idle = '0;
    end else if (s.idle <= LAST) begin
      n.idle = s.idle + W'(1);
      n.timeout = (s.idle == LAST); // [R2] [R4]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign timeout = s.timeout;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  enable_gate_a: assert property (!enable |=> !timeout) // [R4]
    else $error("missing clock reset while detector disabled");
  retrigger_a: assert property (clock_seen |=> !timeout) // [R2]
    else $error("missing clock reset despite a clock edge");
endmodule

// ---- watchdog_timer.sv ----
// watchdog_timer.sv - watchdog counter with power-of-four interval
// assumes restart is a one-cycle pulse and run is low during any system reset
`timescale 1ns/1ps
module watchdog_timer #(
  parameter int W = 21
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] interval,
  output logic            overflow
);
  typedef struct packed {
    logic [W-1:0] count;
    logic         overflow;
  } wdt_state_t;

  wdt_state_t s;
  wdt_state_t n;
  logic [4:0]   shift;
  logic [W-1:0] last;

  // interval is 4^(3+code) = 2^(6+2*code) clocks; code 7 needs all 21 bits
  assign shift = 5'h6 + {1'b0, interval, 1'b0}; // [R16]
  assign last  = (W'(1) << shift) - W'(1);

  always_comb begin
    n = s;
    n.overflow = 1'b0;
    if (restart || !run) begin
      n.count = '0; // [R13]
    end else if (s.count >= last) begin
      n.count = '0;
      n.overflow = 1'b1; // [R11]
    end else begin
      n.count = s.count + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign overflow = s.overflow;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  overflow_point_a: assert property (run && !restart && s.count == last |=> overflow) // [R11]
    else $error("watchdog did not overflow at its limit");
  restart_clear_a: assert property (restart |=> s.count == '0 ##1 !overflow) // [R13]
    else $error("watchdog restart did not clear the count");
endmodule

// ---- reset_source_and_watchdog.sv ----
// reset_source_and_watchdog.sv - reset cause register, reset sequencer, watchdog control
// assumes an APB master, RST as the power-on reset and a free running CLK_SYS
//
// Contract
// R1 - writing software force bit starts internal reset
// R2 - clock idle beyond 100 us causes reset
// R3 - missing clock flag reads one after its reset
// R4 - missing clock resets only when enabled
// R5 - internal sources leave reset pin undriven
// R6 - enabled low comparator holds reset; flag readback
// R7 - enable comparator before its reset enable
// R8 - enabled low convert-start level holds reset
// R9 - convert-start flag reads one after its reset
// R10 - route convert-start before enabling it
// R11 - 21-bit watchdog overflow forces reset
// R12 - reset leaves watchdog running, interval 111b
// R13 - 0xa5 enables and restarts watchdog
// R14 - 0xde then 0xad within 4 disables
// R15 - 0xff locks out disable until reset
// R16 - timeout is four to (3+interval) clocks
// R17 - interval written only when bit 7 zero
// R18 - watchdog read returns interval low bits
// R19 - watchdog read bit 4 shows activity
// R20 - power-on force drives pin, flags power-on
// R21 - no read-modify-write on reset cause register
// R22 - power-on flag cleared by other resets
// R23 - stay in reset 12 clocks after pin
// R24 - other write between disable bytes abandons it
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "rsw_consts.svh"
module reset_source_and_watchdog
  import rsw_pkg::*;
#(
  parameter int MCD_CYCLES = `MCD_TIMEOUT_NS / `CLK_PERIOD_NS
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RST_N_PIN_IN,
  output logic             RST_N_PIN_OUT,
  output logic             RST_N_PIN_OE,
  input  wire logic        COMPARATOR_OUT,
  input  wire logic        CONVERT_START_INPUT_N,
  input  wire logic        MISSING_CLOCK_ENABLE,
  input  wire logic        SYSCLK_RUNNING,
  output logic             SYS_RESET
);
  top_state_t s;
  top_state_t n;
  logic       setup;
  logic       acc;
  logic       hit_rsc;
  logic       hit_wdc;
  logic       wr_rsc;
  logic       wr_wdc;
  logic [7:0] wbyte;
  logic       run;
  logic       pin_low;
  logic       cmp_low;
  logic       cnv_low;
  logic       wd_ovf;
  logic       mcd_to;
  logic       wd_restart;
  logic       src_por;
  logic       src_sw;
  logic       src_any;
  logic       hold_any;

  // bus decode; a transfer completes when the access phase sees our ready
  assign setup   = PSEL && !PENABLE;
  assign acc     = PSEL && PENABLE && s.pready;
  assign hit_rsc = (PADDR[11:2] == `RSC_IDX);
  assign hit_wdc = (PADDR[11:2] == `WDC_IDX);
  assign wr_rsc  = acc && PWRITE && hit_rsc;
  assign wr_wdc  = acc && PWRITE && hit_wdc;
  assign wbyte   = PWDATA[7:0];

  // reset sources; pin, comparator and convert-start are read from the second synchroniser stage
  assign run      = (s.seq == RUN_ST);
  assign pin_low  = !s.pin_sync[1];
  assign cmp_low  = s.cmp_en && !s.cmp_sync[1]; // [R6]
  assign cnv_low  = s.cnv_en && !s.cnv_sync[1]; // [R8]
  assign src_por  = wr_rsc && wbyte[`RSC_POR]; // [R20]
  assign src_sw   = wr_rsc && wbyte[`RSC_SW]; // [R1]
  assign src_any  = pin_low || src_por || cmp_low || cnv_low || wd_ovf || mcd_to || src_sw;
  // our own pin drive counts as a hold so the echo on the pin is not a new cause
  assign hold_any = pin_low || cmp_low || cnv_low || (s.drive != 5'h00);
  assign wd_restart = wr_wdc && (wbyte == `WDC_RESTART) && !s.sys_rst;

  always_comb begin
    n = s;
    // two-flop synchronisers for levels from outside the clock domain
    n.pin_sync = {s.pin_sync[0], RST_N_PIN_IN};
    n.cmp_sync = {s.cmp_sync[0], COMPARATOR_OUT};
    n.cnv_sync = {s.cnv_sync[0], CONVERT_START_INPUT_N};
    n.clk_sync = {s.clk_sync[0], SYSCLK_RUNNING};

    // zero wait state: ready and read data are registered in the setup cycle
    n.pready  = setup;
    n.pslverr = setup && !(hit_rsc || hit_wdc);
    n.prdata  = 32'h0000_0000;
    if (setup && !PWRITE) begin
      if (hit_rsc) begin
        n.prdata[7:0] = {1'b0, s.cause}; // [R3] [R9] [R22]
      end else if (hit_wdc) begin
        n.prdata[7:0] = {3'h0, s.wd_en, 1'b0, s.interval}; // [R18] [R19]
      end
    end

    // written bits act as forces or enables; read bits are causes, hence no rmw
    if (wr_rsc) begin
      n.cmp_en = wbyte[`RSC_CMP]; // [R6]
      n.cnv_en = wbyte[`RSC_CNV]; // [R8]
    end

    // disable window counts down; any watchdog register write except an unlocked 0xde closes it
    if (s.dis_win != 3'h0) begin
      n.dis_win = s.dis_win - 3'h1;
    end
    if (wr_wdc) begin
      n.dis_win = 3'h0; // [R24]
      if (!wbyte[`WDC_CMD_BIT]) begin
        n.interval = wbyte[2:0]; // [R17]
      end else if (wbyte == `WDC_RESTART) begin
        n.wd_en = 1'b1; // [R13]
      end else if (wbyte == `WDC_LOCK) begin
        n.wd_lock = 1'b1; // [R15]
      end else if (wbyte == `WDC_DIS1 && !s.wd_lock) begin
        n.dis_win = `WD_WINDOW; // [R14]
      end else if (wbyte == `WDC_DIS2 && !s.wd_lock && s.dis_win != 3'h0) begin
        n.wd_en = 1'b0; // [R14]
      end
    end

    // power-on pin drive runs down on its own
    if (s.drive != 5'h00) begin
      n.drive = s.drive - 5'h01;
    end

    case (s.seq)
      RUN_ST: begin
        if (src_any) begin
          n.seq = HOLD_ST;
          // one cause recorded, every other flag cleared
          n.cause = 7'h00;
          if (pin_low) begin
            n.cause[`RSC_PIN] = 1'b1;
          end else if (src_por) begin
            n.cause[`RSC_POR] = 1'b1; // [R20] [R22]
            n.drive = `POR_DRIVE;
          end else if (cmp_low) begin
            n.cause[`RSC_CMP] = 1'b1; // [R6]
          end else if (cnv_low) begin
            n.cause[`RSC_CNV] = 1'b1; // [R9]
          end else if (wd_ovf) begin
            n.cause[`RSC_WDT] = 1'b1; // [R11]
          end else if (mcd_to) begin
            n.cause[`RSC_MCD] = 1'b1; // [R3]
          end else begin
            n.cause[`RSC_SW] = 1'b1; // [R1]
          end
          // watchdog comes back enabled, unlocked, longest interval
          n.wd_en    = 1'b1; // [R12]
          n.wd_lock  = 1'b0; // [R15]
          n.interval = `WD_INTERVAL_RST; // [R12]
          n.dis_win  = 3'h0;
        end
      end
      HOLD_ST: begin
        if (!hold_any) begin
          n.seq     = STRETCH_ST;
          n.stretch = `PIN_STRETCH; // [R23]
        end
      end
      STRETCH_ST: begin
        if (hold_any) begin
          n.seq = HOLD_ST;
        end else if (s.stretch == 4'h0) begin
          n.seq = RUN_ST; // [R23]
        end else begin
          n.stretch = s.stretch - 4'h1;
        end
      end
      default: begin
        n.seq = HOLD_ST;
      end
    endcase

    // only the power-on force drives the pin; all else leaves it alone
    n.pin_oe  = (n.drive != 5'h00); // [R5] [R20]
    n.pin_out = 1'b0;
    n.sys_rst = (n.seq != RUN_ST);
  end

  // power-on reset: held in stretch with the power-on cause
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s          <= '0;
      s.seq      <= STRETCH_ST;
      s.stretch  <= `PIN_STRETCH;
      s.cause    <= 7'h02;
      s.wd_en    <= 1'b1;
      s.interval <= `WD_INTERVAL_RST;
      s.sys_rst  <= 1'b1;
      // synchronisers start at the idle level so release shows no false low
      s.pin_sync <= 2'h3;
      s.cmp_sync <= 2'h3;
      s.cnv_sync <= 2'h3;
      s.clk_sync <= 2'h3;
    end else begin
      s <= n;
    end
  end

  // watchdog only counts while enabled and the device is out of reset
  watchdog_timer #(
    .W (`WD_WIDTH)
  ) u_wdt (
    .clk      (CLK_SYS),
    .rst      (RST),
    .run      (s.wd_en && run),
    .restart  (wd_restart),
    .interval (s.interval),
    .overflow (wd_ovf)
  );

  // the qualified clock is seen as a level; a stopped clock is a missing edge
  missing_clock_monitor #(
    .CYCLES (MCD_CYCLES)
  ) u_mcd (
    .clk        (CLK_SYS),
    .rst        (RST),
    .enable     (MISSING_CLOCK_ENABLE),
    .clock_seen (s.clk_sync[1]),
    .timeout    (mcd_to)
  );

  assign PRDATA        = s.prdata;
  assign PREADY        = s.pready;
  assign PSLVERR       = s.pslverr;
  assign RST_N_PIN_OUT = s.pin_out;
  assign RST_N_PIN_OE  = s.pin_oe;
  assign SYS_RESET     = s.sys_rst;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // multi-step behaviours: pin release, then the two disable bytes
  sequence pin_release_s;
    pin_low ##1 !pin_low;
  endsequence
  sequence dis_pair_s;
    wr_wdc && wbyte == `WDC_DIS1 && !s.wd_lock ##2 wr_wdc && wbyte == `WDC_DIS2;
  endsequence

  sw_force_a: assert property (run && src_sw && !src_por && !pin_low // [R1]
                               |=> SYS_RESET && !RST_N_PIN_OE)
    else $error("software force did not give a pin-free reset");
  mcd_flag_a: assert property (run && mcd_to && !src_por && !pin_low // [R3]
                               && !cmp_low && !cnv_low && !wd_ovf |=> s.cause == 7'h04)
    else $error("missing clock cause not recorded");
  cmp_hold_a: assert property (cmp_low |=> SYS_RESET) // [R6]
    else $error("low comparator did not hold reset");
  cnv_hold_a: assert property (cnv_low |=> SYS_RESET) // [R8]
    else $error("low convert-start did not hold reset");
  pin_stretch_a: assert property (pin_release_s |-> SYS_RESET [*8]) // [R23]
    else $error("reset released too soon after pin");
  release_point_a: assert property ($fell(SYS_RESET) |-> $past(s.seq) == STRETCH_ST // [R23]
                                    && $past(s.stretch) == 4'h0)
    else $error("reset released before stretch ran out");
  wd_disable_a: assert property (dis_pair_s |=> !s.wd_en || SYS_RESET) // [R14]
    else $error("disable pair did not stop the watchdog");
  lock_hold_a: assert property (s.wd_lock && wr_wdc && wbyte == `WDC_DIS1 // [R15]
                                |=> s.dis_win == 3'h0)
    else $error("disable sequence armed while locked");
  interval_wr_a: assert property (run && !src_any && wr_wdc && !wbyte[7] // [R17]
                                  |=> s.interval == $past(wbyte[2:0]))
    else $error("interval write lost");
  reset_wd_a: assert property ($rose(SYS_RESET) |-> s.wd_en && s.interval == 3'h7) // [R12]
    else $error("watchdog not re-armed by reset");
  por_force_a: assert property (run && src_por && !pin_low // [R20]
                                |=> RST_N_PIN_OE && !RST_N_PIN_OUT && s.cause == 7'h02)
    else $error("power-on force did not drive the pin");

  // the pin, the recorded causes, the status read and bytes that must leave the watchdog alone
  pin_oe_por_a: assert property (RST_N_PIN_OE |-> s.cause == 7'h02) // [R5]
    else $error("reset pin driven by a source other than power-on force");
  cmp_flag_a: assert property (run && cmp_low && !pin_low && !src_por // [R6]
                               |=> s.cause == 7'h20)
    else $error("comparator cause not recorded");
  cnv_flag_a: assert property (run && cnv_low && !pin_low && !src_por && !cmp_low // [R9]
                               |=> s.cause == 7'h40)
    else $error("convert-start cause not recorded");
  status_read_a: assert property (setup && !PWRITE && hit_wdc // [R19]
                                  |=> PRDATA[`WDC_STATUS] == $past(s.wd_en))
    else $error("watchdog status bit does not show activity");
  lock_keep_a: assert property (run && !src_any && wr_wdc && wbyte == `WDC_LOCK // [R15]
                                |=> s.wd_en == $past(s.wd_en))
    else $error("lock byte changed the watchdog enable");
  dis_alone_a: assert property (run && !src_any && wr_wdc && wbyte == `WDC_DIS2 // [R24]
                                && s.dis_win == 3'h0 |=> s.wd_en == $past(s.wd_en))
    else $error("second disable byte alone changed the watchdog");
endmodule

// ---- tb_top.sv ----
// tb_top.sv - self-checking bench for the reset source and watchdog block
// assumes the design files and rsw_consts.svh are compiled before it
`timescale 1ns/1ps
`include "rsw_consts.svh"
module tb_top;
  localparam logic [11:0] A_RSC = {`RSC_IDX, 2'b00};
  localparam logic [11:0] A_WDC = {`WDC_IDX, 2'b00};
  typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] e; logic r;} row_t;
  // write then read back; a byte with bit 7 set must not touch the interval
  row_t rows [6] = '{'{A_WDC, 8'h01, 8'h11, 1'b0}, '{A_WDC, 8'h83, 8'h11, 1'b0},
                     '{A_WDC, 8'h06, 8'h16, 1'b0}, '{A_WDC, 8'ha5, 8'h16, 1'b0},
                     '{12'h000, 8'h55, 8'h00, 1'b1}, '{A_WDC, 8'h05, 8'h15, 1'b0}};
  logic        clk = 0;
  logic        rst = 1;
  logic        psel = 0;
  logic        pen = 0;
  logic        pwr = 0;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0;
  logic [31:0] prd;
  logic        prdy, perr, pin_out, pin_oe, sys_rst;
  logic        pin_n = 1;
  logic        cmp = 1;
  logic        cnv_n = 1;
  logic        mce = 0;
  logic        run = 1;
  int          oe_cnt = 0;
  int          oe_mark = 0;
  logic [31:0] rd;
  logic        er;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n;
  reset_source_and_watchdog #(.MCD_CYCLES(20)) reset_source_and_watchdog_i (
    .CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .RST_N_PIN_IN(pin_n),
    .RST_N_PIN_OUT(pin_out), .RST_N_PIN_OE(pin_oe), .COMPARATOR_OUT(cmp),
    .CONVERT_START_INPUT_N(cnv_n), .MISSING_CLOCK_ENABLE(mce),
    .SYSCLK_RUNNING(run), .SYS_RESET(sys_rst));
  always #5 clk = ~clk;
  // hang guard; the whole sequence needs a few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pin_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  function automatic logic [31:0] fl(input int b);
    return 32'h1 << b;
  endfunction
  function automatic logic [31:0] wd(input logic act, input logic [2:0] iv);
    return (32'(act) << `WDC_STATUS) | 32'(iv);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; b2b keeps psel up so the next setup follows at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic b2b = 0);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    // no fixed wait assumed; only the global cycle ceiling ends a stuck transfer
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    pen <= 0;
    if (!b2b) begin
      psel <= 0;
      @(posedge clk);
    end
  endtask
  // waits for the system reset level, counting edges, with a bound
  task automatic wait_sys(input logic lvl, output int c);
    c = 0;
    while (sys_rst !== lvl && c < 300) begin
      @(posedge clk);
      c++;
    end
    if (c == 300) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, sys_rst, lvl);
    end
  endtask
  task automatic cause_is(input logic [31:0] e);
    wait_sys(1'b0, n);
    apb(0, A_RSC, 0);
    chk(rd, e);
  endtask
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    cause_is(fl(`RSC_POR));
    apb(0, A_WDC, 0);
    chk(rd, wd(1, `WD_INTERVAL_RST));
    $display("test done: reset state");
    foreach (rows[i]) begin
      apb(1, rows[i].a, 32'(rows[i].d));
      apb(0, rows[i].a, 0);
      chk(rd, 32'(rows[i].e));
      chk(er, rows[i].r);
    end
    $display("test done: register rows");
    // disable attempts: one edge past the window, interrupted, then on its last edge
    apb(1, A_WDC, `WDC_DIS1);
    repeat (2) @(posedge clk);
    apb(1, A_WDC, `WDC_DIS2);
    apb(0, A_WDC, 0);
    chk(rd, wd(1, 5));
    apb(1, A_WDC, `WDC_DIS1, 1);
    apb(1, A_WDC, 32'h05, 1);
    apb(1, A_WDC, `WDC_DIS2);
    apb(0, A_WDC, 0);
    chk(rd, wd(1, 5));
    apb(1, A_WDC, `WDC_DIS1);
    @(posedge clk);
    apb(1, A_WDC, `WDC_DIS2);
    apb(0, A_WDC, 0);
    chk(rd, wd(0, 5));
    apb(1, A_WDC, `WDC_RESTART);
    apb(1, A_WDC, `WDC_LOCK);
    apb(0, A_WDC, 0);
    chk(rd, wd(1, 5));
    apb(1, A_WDC, `WDC_DIS1, 1);
    apb(1, A_WDC, `WDC_DIS2);
    apb(0, A_WDC, 0);
    chk(rd, wd(1, 5));
    $display("test done: disable and lock");
    // restart first so the shortest interval starts from a fresh count
    apb(1, A_WDC, `WDC_RESTART, 1);
    apb(1, A_WDC, 32'h00);
    wait_sys(1'b1, n);
    chk(n >= 4 ** 3 - 8 && n <= 4 ** 3 + 4, 1);
    cause_is(fl(`RSC_WDT));
    apb(0, A_WDC, 0);
    chk(rd, wd(1, `WD_INTERVAL_RST));
    apb(1, A_WDC, `WDC_DIS1, 1);
    apb(1, A_WDC, `WDC_DIS2);
    apb(0, A_WDC, 0);
    chk(rd, wd(0, `WD_INTERVAL_RST));
    $display("test done: watchdog overflow");
    apb(1, A_RSC, 32'h00);
    repeat (5) @(posedge clk);
    chk(sys_rst, 0);
    oe_mark = oe_cnt;
    apb(1, A_RSC, fl(`RSC_SW));
    wait_sys(1'b1, n);
    chk(n <= 3, 1);
    cause_is(fl(`RSC_SW));
    chk(oe_cnt - oe_mark, 0);
    apb(1, A_RSC, fl(`RSC_POR));
    cause_is(fl(`RSC_POR));
    chk(oe_cnt - oe_mark, `POR_DRIVE);
    chk(pin_out, 0);
    $display("test done: forced resets");
    cmp <= 0;
    repeat (20) @(posedge clk);
    chk(sys_rst, 0);
    apb(1, A_RSC, fl(`RSC_CMP));
    wait_sys(1'b1, n);
    repeat (40) @(posedge clk);
    chk(sys_rst, 1);
    cmp <= 1;
    cause_is(fl(`RSC_CMP));
    apb(1, A_RSC, fl(`RSC_CNV));
    cnv_n <= 0;
    wait_sys(1'b1, n);
    repeat (40) @(posedge clk);
    chk(sys_rst, 1);
    cnv_n <= 1;
    cause_is(fl(`RSC_CNV));
    apb(1, A_RSC, 32'h00);
    $display("test done: level sources");
    // idle clock with the detector off must not reset
    run <= 0;
    repeat (40) @(posedge clk);
    chk(sys_rst, 0);
    run <= 1;
    repeat (5) @(posedge clk);
    mce <= 1;
    run <= 0;
    wait_sys(1'b1, n);
    chk(n >= 20 && n <= 26, 1);
    run <= 1;
    cause_is(fl(`RSC_MCD));
    mce <= 0;
    oe_mark = oe_cnt;
    pin_n <= 0;
    repeat (5) @(posedge clk);
    pin_n <= 1;
    wait_sys(1'b0, n);
    chk(n >= 12 && n <= 20, 1);
    cause_is(fl(`RSC_PIN));
    chk(oe_cnt - oe_mark, 0);
    $display("test done: clock and pin");
    print_verdict();
  end
endmodule
